/* shared/lsf_pkg.sv */
`default_nettype none
package lsf_pkg;
    localparam int unsigned FIFO_DEPTH   = 128;
    localparam int unsigned PTR_W        = 7;
    localparam int unsigned CNT_W        = 8;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned SYNC_STAGES  = 3;

    // line status bit positions
    localparam int unsigned LS_DATA_READY  = 0;
    localparam int unsigned LS_OVERRUN     = 1;
    localparam int unsigned LS_PARITY      = 2;
    localparam int unsigned LS_FRAMING     = 3;
    localparam int unsigned LS_BREAK       = 4;
    localparam int unsigned LS_FIFO_ERROR  = 7;

    localparam logic [7:0]       LINE_STATUS_RESET = 8'h00;
    localparam logic [CNT_W-1:0] HOLDING_DEPTH     = 8'h01;
    localparam logic [CNT_W-1:0] FIFO_DEPTH_CNT    = 8'h80;
    localparam logic [CNT_W-1:0] CNT_ONE           = 8'h01;
    localparam logic [PTR_W-1:0] PTR_ONE           = 7'h01;
    localparam logic [DATA_W-1:0] BREAK_CHAR       = 8'h00;

    // character handed over by the deserializer
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
        logic              parityErr;
        logic              framingErr;
        logic              lineLowFrame;
    } lsf_rx_char_s;

    // one stored entry: data plus its own error tags
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              brk;
        logic              framingErr;
        logic              parityErr;
    } lsf_entry_s;
endpackage
`default_nettype wire

/* rtl/lsf_line_status.sv */
// What this block does
// - break flag rises when receive line stayed low a whole character frame
// - fifo mode stores one break character per continuous break condition
// - framing flag rises when received character lacks a valid stop bit
// - fifo mode reports framing error of head character, each tagged separately
// - parity flag rises when received parity bit mismatches configured parity
// - fifo mode shows parity error of head character, not newest one
// - overrun flag rises when character completes while fifo already full
// - on overrun shift register is overwritten, fifo contents stay intact
// - data ready is one while holding register or fifo holds a character
// - data ready is zero once nothing unread remains
// - overrun, parity and framing flags read zero after reset
// - fifo mode: fifo error summary set while any stored character carries an error tag, zero in plain mode
// - break flag sits in bit four, zero when no break seen
`timescale 1ns/1ns
`default_nettype none
module lsf_line_status
    import lsf_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                rxLine,
    input  wire lsf_rx_char_s        rxChar,
    input  wire logic                fifoEnable,
    input  wire logic                fifoClear,
    input  wire logic                rxDataRead,
    input  wire logic                lineStatusRead,
    output logic [DATA_W-1:0]        rxData,
    output logic [DATA_W-1:0]        shiftData,
    output logic [7:0]               line_status,
    output logic                     fifoFull,
    output logic                     fifoEmpty
);

    ////////////////////////////////////////////////////////////////////////////////
    // receive line filter for break end

    logic [SYNC_STAGES-1:0] syncQ;
    logic [SYNC_STAGES-1:0] syncD;
    logic                   lineHighQ;
    logic                   lineHighD;

    always_comb begin
        syncD     = {syncQ[SYNC_STAGES-2:0], rxLine};
        lineHighD = lineHighQ;
        if (syncQ[1] == syncQ[2]) begin
            lineHighD = syncQ[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            syncQ     <= '1;
            lineHighQ <= 1'b1;
        end else begin
            syncQ     <= syncD;
            lineHighQ <= lineHighD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // storage: holding register in plain mode, full depth in fifo mode

    lsf_entry_s       memQ [FIFO_DEPTH];
    lsf_entry_s       memD [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtrQ;
    logic [PTR_W-1:0] wrPtrD;
    logic [PTR_W-1:0] rdPtrQ;
    logic [PTR_W-1:0] rdPtrD;
    logic [CNT_W-1:0] countQ;
    logic [CNT_W-1:0] countD;
    logic [CNT_W-1:0] errCountQ;
    logic [CNT_W-1:0] errCountD;
    logic             breakHoldQ;
    logic             breakHoldD;
    logic             overrunQ;
    logic             overrunD;
    logic [DATA_W-1:0] shiftQ;
    logic [DATA_W-1:0] shiftD;
    logic [7:0]       statusQ;
    logic [7:0]       statusD;
    logic [DATA_W-1:0] rxDataQ;
    logic [DATA_W-1:0] rxDataD;
    logic             fullQ;
    logic             fullD;
    logic             emptyQ;
    logic             emptyD;

    function automatic logic entry_has_error(input lsf_entry_s e);
        entry_has_error = e.brk | e.framingErr | e.parityErr;
    endfunction

    function automatic logic at_capacity(input logic [CNT_W-1:0] cnt, input logic fifoOn);
        at_capacity = fifoOn ? (cnt >= FIFO_DEPTH_CNT) : (cnt >= HOLDING_DEPTH);
    endfunction

    lsf_entry_s newEntry;
    lsf_entry_s headEntry;
    lsf_entry_s nextHead;
    logic       isBreak;
    logic       dropBreak;
    logic       isFull;
    logic       doPush;
    logic       doPop;

    always_comb begin
        isBreak    = rxChar.lineLowFrame;
        dropBreak  = isBreak && breakHoldQ && fifoEnable;
        isFull     = at_capacity(countQ, fifoEnable);
        doPop      = rxDataRead && (countQ != '0);
        doPush     = rxChar.valid && !dropBreak && !isFull;
        headEntry  = memQ[rdPtrQ];

        newEntry.data       = isBreak ? BREAK_CHAR : rxChar.data;
        newEntry.brk        = isBreak;
        newEntry.framingErr = rxChar.framingErr;
        newEntry.parityErr  = rxChar.parityErr;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // entry storage: written only on an accepted push

    always_comb begin
        memD = memQ;
        if (doPush) begin
            memD[wrPtrQ] = newEntry;
        end
    end

    generate
        for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_mem
            always_ff @(posedge mclk) begin
                memQ[i] <= memD[i];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // write and read pointers

    always_comb begin
        wrPtrD = wrPtrQ;
        rdPtrD = rdPtrQ;
        if (doPush) begin
            wrPtrD = wrPtrQ + PTR_ONE;
        end
        if (doPop) begin
            rdPtrD = rdPtrQ + PTR_ONE;
        end
        if (fifoClear) begin
            wrPtrD = '0;
            rdPtrD = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
        end else begin
            wrPtrQ <= wrPtrD;
            rdPtrQ <= rdPtrD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fill level and number of tagged entries held

    always_comb begin
        countD    = countQ + (doPush ? CNT_ONE : '0) - (doPop ? CNT_ONE : '0);
        errCountD = errCountQ
                  + ((doPush && entry_has_error(newEntry)) ? CNT_ONE : '0)
                  - ((doPop && entry_has_error(headEntry)) ? CNT_ONE : '0);
        if (fifoClear) begin
            countD    = '0;
            errCountD = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            countQ    <= '0;
            errCountQ <= '0;
        end else begin
            countQ    <= countD;
            errCountQ <= errCountD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // break hold: one break character per low period in fifo mode; line returning high re-arms

    always_comb begin
        breakHoldD = breakHoldQ;
        if (lineHighQ) begin
            breakHoldD = 1'b0;
        end
        if (rxChar.valid && isBreak) begin
            breakHoldD = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            breakHoldQ <= 1'b0;
        end else begin
            breakHoldQ <= breakHoldD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shift register always takes the newest character

    always_comb begin
        shiftD = rxChar.valid ? newEntry.data : shiftQ;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shiftQ <= '0;
        end else begin
            shiftQ <= shiftD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // overrun: a set wins over a status read in the same cycle

    always_comb begin
        overrunD = overrunQ;
        if (lineStatusRead) begin
            overrunD = 1'b0;
        end
        if (rxChar.valid && !dropBreak && isFull) begin
            overrunD = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            overrunQ <= 1'b0;
        end else begin
            overrunQ <= overrunD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status and head data as they will stand after this edge

    always_comb begin
        nextHead = memD[rdPtrD];
        statusD  = LINE_STATUS_RESET;
        statusD[LS_DATA_READY] = (countD != '0);
        statusD[LS_OVERRUN]    = overrunD;
        statusD[LS_PARITY]     = (countD != '0) && nextHead.parityErr;
        statusD[LS_FRAMING]    = (countD != '0) && nextHead.framingErr;
        statusD[LS_BREAK]      = (countD != '0) && nextHead.brk;
        statusD[LS_FIFO_ERROR] = fifoEnable && (errCountD != '0);
        rxDataD = (countD != '0) ? nextHead.data : '0;
        fullD   = at_capacity(countD, fifoEnable);
        emptyD  = (countD == '0);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            statusQ <= LINE_STATUS_RESET;
            rxDataQ <= '0;
            fullQ   <= 1'b0;
            emptyQ  <= 1'b1;
        end else begin
            statusQ <= statusD;
            rxDataQ <= rxDataD;
            fullQ   <= fullD;
            emptyQ  <= emptyD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rxData      = rxDataQ;
    assign shiftData   = shiftQ;
    assign line_status = statusQ;
    assign fifoFull    = fullQ;
    assign fifoEmpty   = emptyQ;

endmodule
`default_nettype wire

/* tb/lsf_line_status_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module lsf_line_status_properties
    import lsf_pkg::*;
(
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire lsf_rx_char_s      rxChar,
    input wire logic              fifoClear,
    input wire logic              rxDataRead,
    input wire logic              lineStatusRead,
    input wire logic [DATA_W-1:0] rxData,
    input wire logic [DATA_W-1:0] shiftData,
    input wire logic [7:0]        line_status,
    input wire logic              fifoFull,
    input wire logic              fifoEmpty
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ordinary character, not a break and not cleared away
    wire logic push = rxChar.valid && !fifoClear && !rxChar.lineLowFrame;
    rst_clear_a: assert property ($past(sys_rst) |-> line_status == 8'h00 && fifoEmpty)
        else $error("flags not clear after reset");
    ready_level_a: assert property (line_status[LS_DATA_READY] == !fifoEmpty)
        else $error("ready disagrees with empty");
    push_ready_a: assert property (push && !fifoFull |=> line_status[LS_DATA_READY])
        else $error("stored char not ready");
    overrun_set_a: assert property (push && fifoFull |=> line_status[LS_OVERRUN])
        else $error("overrun not set");
    overrun_keep_a: assert property (push && fifoFull && !rxDataRead |=>
        rxData == $past(rxData) && shiftData == $past(rxChar.data)) else $error("overrun data wrong");
    overrun_clear_a: assert property (lineStatusRead && !rxChar.valid |=> !line_status[LS_OVERRUN])
        else $error("overrun not cleared");
    empty_pop_a: assert property (fifoEmpty && rxDataRead && !rxChar.valid |=> fifoEmpty)
        else $error("pop of empty storage");
    empty_flags_a: assert property (fifoEmpty |-> line_status[LS_BREAK:LS_PARITY] == 3'b000)
        else $error("head flags set while empty");
endmodule
bind lsf_line_status lsf_line_status_properties i_props (.mclk(mclk), .sys_rst(sys_rst), .rxChar(rxChar),
    .fifoClear(fifoClear), .rxDataRead(rxDataRead), .lineStatusRead(lineStatusRead), .rxData(rxData),
    .shiftData(shiftData), .line_status(line_status), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));
`default_nettype wire

/* tb/lsf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lsf_host_model
    import lsf_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              wantData,
    input  wire logic              wantStatus,
    input  wire logic [DATA_W-1:0] rxData,
    output logic                   rxDataRead,
    output logic                   lineStatusRead,
    output logic [DATA_W-1:0]      readByte
);
    assign rxDataRead     = wantData;
    assign lineStatusRead = wantStatus;
    // byte the cpu latches at the edge its read is taken
    always_ff @(posedge mclk) begin
        if (wantData) begin
            readByte <= rxData;
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import lsf_pkg::*;
;
    logic         mclk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         rxLine = 1'b1;
    lsf_rx_char_s rxChar = '0;
    logic         fifoEnable = 1'b0;
    logic         fifoClear = 1'b0;
    logic         wantData = 1'b0;
    logic         wantStatus = 1'b0;
    logic         rxDataRead, lineStatusRead, fifoFull, fifoEmpty;
    logic [7:0]   rxData, shiftData, line_status, readByte;
    int           err_count = 0;
    int           total_checks = 0;
    int           cycles = 0;
    always #50 mclk = ~mclk;
    lsf_line_status i_lsf_line_status (.mclk(mclk), .sys_rst(sys_rst), .rxLine(rxLine), .rxChar(rxChar),
        .fifoEnable(fifoEnable), .fifoClear(fifoClear), .rxDataRead(rxDataRead), .lineStatusRead(lineStatusRead),
        .rxData(rxData), .shiftData(shiftData), .line_status(line_status), .fifoFull(fifoFull), .fifoEmpty(fifoEmpty));
    lsf_host_model i_lsf_host_model (.mclk(mclk), .wantData(wantData), .wantStatus(wantStatus), .rxData(rxData),
        .rxDataRead(rxDataRead), .lineStatusRead(lineStatusRead), .readByte(readByte));
    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            final_report();
        end
    end
    task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // one-cycle pulse of a character and/or host reads; err is {brk, frm, par}, rd is {data, status}
    task automatic op(input logic v, input logic [7:0] d, input logic [2:0] err, input logic [1:0] rd);
        @(posedge mclk);
        rxChar <= '{v, d, err[0], err[1], err[2]};
        wantData <= rd[1];
        wantStatus <= rd[0];
        @(posedge mclk);
        rxChar.valid <= 1'b0;
        wantData <= 1'b0;
        wantStatus <= 1'b0;
        @(negedge mclk);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        cmp8(8'h00, line_status);
        op(1'b1, 8'h41, 3'b001, 2'b00);
        cmp8(8'h05, line_status);
        op(1'b1, 8'h42, 3'b010, 2'b00);
        cmp8(8'h07, line_status);
        cmp8(8'h41, rxData);
        cmp8(8'h42, shiftData);
        op(1'b0, 8'h00, 3'b000, 2'b01);
        cmp8(8'h05, line_status);
        op(1'b0, 8'h00, 3'b000, 2'b10);
        cmp8(8'h41, readByte);
        cmp8(8'h00, line_status);
        @(posedge mclk);
        fifoEnable <= 1'b1;
        op(1'b1, 8'h10, 3'b011, 2'b00);
        op(1'b1, 8'h11, 3'b000, 2'b00);
        cmp8(8'h8d, line_status);
        op(1'b0, 8'h00, 3'b000, 2'b10);
        cmp8(8'h01, line_status);
        cmp8(8'h11, rxData);
        op(1'b0, 8'h00, 3'b000, 2'b10);
        rxLine <= 1'b0;
        // a break completes only after the line has been low a whole frame
        repeat (4) @(posedge mclk);
        op(1'b1, 8'h00, 3'b100, 2'b00);
        op(1'b1, 8'h00, 3'b100, 2'b00);
        cmp8(8'h91, line_status);
        op(1'b0, 8'h00, 3'b000, 2'b10);
        cmp8(8'h00, line_status);
        rxLine <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 128; i++) begin
            op(1'b1, i[7:0], 3'b000, 2'b00);
        end
        cmp8(8'h01, {7'h00, fifoFull});
        op(1'b1, 8'hee, 3'b000, 2'b00);
        cmp8(8'h03, line_status);
        cmp8(8'hee, shiftData);
        op(1'b0, 8'h00, 3'b000, 2'b11);
        cmp8(8'h01, line_status);
        cmp8(8'h01, rxData);
        @(posedge mclk);
        fifoClear <= 1'b1;
        @(posedge mclk);
        fifoClear <= 1'b0;
        @(negedge mclk);
        cmp8(8'h01, {7'h00, fifoEmpty});
        op(1'b1, 8'h5a, 3'b010, 2'b00);
        cmp8(8'h89, line_status);
        cmp8(8'h5a, rxData);
        final_report();
    end
endmodule
`default_nettype wire
